// [core/bescp_parser.sv]
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module bescp_parser
	import bescp_pkg::*;
(
	// clock, reset, enable
	input  wire logic           clk_i,
	input  wire logic           rst_i,
	input  wire logic           ce_i,
	// wishbone classic slave
	input  wire logic           wb_cyc_i,
	input  wire logic           wb_stb_i,
	input  wire logic           wb_we_i,
	input  wire logic [7:0]     wb_adr_i,
	input  wire logic [3:0]     wb_sel_i,
	input  wire logic [31:0]    wb_dat_i,
	output logic [31:0]         wb_dat_o,
	output logic                wb_ack_o,
	// host byte stream
	input  wire logic           in_valid_i,
	input  wire logic [7:0]     in_data_i,
	output logic                in_ready_o,
	// text toward print buffers
	output logic                out_valid_o,
	output logic [7:0]          out_data_o,
	input  wire logic           out_ready_i,
	// print engine
	input  wire logic           engine_idle_i,
	output bescp_ctl_type       ctl_o,
	output logic [4:0]          top_steps_o,
	output logic [4:0]          bottom_steps_o,
	output logic [5:0]          lines_o
);

	// lines per page at normal and double line spacing for 4..14 inch sheets
	// one row per sheet: normal 6 dot, normal 8 dot, double 6 dot, double 8 dot
	function automatic logic [5:0] lpp_base(input logic [3:0] sheet, input logic dot8,
		input logic dbl);
		logic [23:0] row;
		row = 24'h0;
		case (sheet)
			4'h4: row = {6'd9, 6'd7, 6'd6, 6'd5};
			4'h5: row = {6'd11, 6'd9, 6'd7, 6'd6};
			4'h6: row = {6'd14, 6'd11, 6'd9, 6'd8};
			4'h7: row = {6'd16, 6'd13, 6'd11, 6'd9};
			4'h8: row = {6'd19, 6'd15, 6'd12, 6'd11};
			4'h9: row = {6'd21, 6'd17, 6'd14, 6'd12};
			4'ha: row = {6'd24, 6'd19, 6'd16, 6'd13};
			4'hb: row = {6'd26, 6'd21, 6'd17, 6'd15};
			4'hc: row = {6'd29, 6'd23, 6'd19, 6'd16};
			4'hd: row = {6'd31, 6'd25, 6'd21, 6'd18};
			default: row = {6'd34, 6'd27, 6'd22, 6'd19};
		endcase
		case ({dbl, dot8})
			2'b00: lpp_base = row[23:18];
			2'b01: lpp_base = row[17:12];
			2'b10: lpp_base = row[11:6];
			default: lpp_base = row[5:0];
		endcase
	endfunction

	// height of n lines in 0.3175 mm units
	// a margin step is two of these units, so margins add as twice the steps
	function automatic logic [11:0] line_steps(input logic [5:0] n, input logic dbl);
		line_steps = dbl ? {1'b0, n, 5'h0} : {2'b0, n, 4'h0};
	endfunction

	// true for an ascii decimal digit
	function automatic logic is_digit(input logic [7:0] b);
		is_digit = (b >= BESCP_DIG_0) && (b <= BESCP_DIG_9);
	endfunction

	// state
	bescp_state_type state_r, state_nxt;
	bescp_cfg_type   cfg_r;
	bescp_ctl_type   ctl_r, ctl_nxt;
	logic            ffm_r;
	logic [4:0]      margin_r;
	logic [7:0]      cmd_r;
	logic [7:0]      tens_r;
	logic [5:0]      line_cnt_r;
	logic            held_r;
	logic            ack_r;
	logic [31:0]     rdat_r;
	logic [5:0]      lpp_eff;
	logic            buf_ready;

	// ---------------- byte acceptance ----------------
	// escape and argument states take any byte, flush states take none
	wire parse_st  = (state_r == BESCP_S_TEXT) || (state_r == BESCP_S_ESC) ||
		(state_r == BESCP_S_ARG1) || (state_r == BESCP_S_ARG2);
	wire is_text   = (state_r == BESCP_S_TEXT) && (in_data_i != BESCP_ESC);
	// text waits for buffer room; command bytes never do
	// ready looks at the offered byte, so the host must hold data with valid
	assign in_ready_o = parse_st && (!is_text || buf_ready);
	wire take      = ce_i && in_valid_i && in_ready_o;
	wire push_text = take && is_text;

	// ---------------- page geometry ----------------
	// page adjust trims the table value; writes above nine are refused
	wire [5:0] base_lines = lpp_base(cfg_r.sheet_in, cfg_r.dot8, cfg_r.dbl_space);
	assign lpp_eff = base_lines - {2'b0, cfg_r.adjust};
	wire single_top = !cfg_r.duplex && !cfg_r.zfold;
	// lines so far plus the closing one and one line more, plus the top offset
	wire [5:0]  next_line = line_cnt_r + 6'h1;
	wire [11:0] used_steps = line_steps(next_line + 6'h1, cfg_r.dbl_space) +
		{6'h0, margin_r, 1'b0};
	wire [11:0] cap_steps  = line_steps(lpp_eff, cfg_r.dbl_space);
	// single-sided offset pushes text down; a line past the bottom wraps
	wire no_room   = single_top && (used_steps > cap_steps);
	wire page_full = (next_line >= lpp_eff) || no_room;
	wire end_line  = push_text && (in_data_i == BESCP_LF);
	wire end_ff    = push_text && (in_data_i == BESCP_FF) && ffm_r;
	wire close_pg  = (end_line && page_full) || end_ff;

	// ---------------- margin command decode ----------------
	// tens_r holds ff after a non-digit, so the range test rejects it
	// ten times the tens digit as eight plus two, no multiplier
	wire [7:0] units     = in_data_i - BESCP_DIG_0;
	wire [7:0] tens_val  = {tens_r[4:0], 3'h0} + {tens_r[6:0], 1'b0};
	wire [7:0] mrg_val   = tens_val + units;
	wire       mrg_legal = is_digit(in_data_i) && (tens_r <= 8'h09) &&
		(mrg_val <= {3'h0, BESCP_MARGIN_MAX});
	wire       ffm_digit = (in_data_i == BESCP_DIG_0) || (in_data_i == BESCP_DIG_1);

	// ---------------- parser and volume sequencer ----------------
	// flush, blank and home run once per soft form feed; the host is stalled
	// meanwhile, so no byte slips between the last page and the blank sheet
	always_comb begin
		state_nxt = state_r;
		ctl_nxt   = '0;
		case (state_r)
			BESCP_S_TEXT: begin
				if (take && !is_text) state_nxt = BESCP_S_ESC;
				if (close_pg && (!cfg_r.duplex || held_r)) begin
					// pairs go out together for two-sided sheets
					ctl_nxt.release_pg = 1'b1;
					ctl_nxt.pages      = (cfg_r.duplex) ? 2'h2 : 2'h1;
				end
			end
			BESCP_S_ESC: begin
				if (take) begin
					if (in_data_i == BESCP_CMD_FFM || in_data_i == BESCP_CMD_MRG) begin
						state_nxt = BESCP_S_ARG1;
					end else if (in_data_i == BESCP_CMD_SFF) begin
						// everything left, partial page too, goes to print
						ctl_nxt.release_pg = held_r || (line_cnt_r != 6'h0);
						ctl_nxt.pages      = {1'b0, held_r} + {1'b0, line_cnt_r != 6'h0};
						state_nxt          = BESCP_S_FLUSH;
					end else if (in_data_i == BESCP_CMD_RST) begin
						// same as the panel reset key
						ctl_nxt.discard = 1'b1;
						ctl_nxt.origin  = 1'b1;
						state_nxt       = BESCP_S_TEXT;
					end else begin
						// other commands are handled elsewhere and dropped here
						state_nxt = BESCP_S_TEXT;
					end
				end
			end
			// an escape byte inside the arguments counts as an argument
			BESCP_S_ARG1: begin
				if (take) begin
					state_nxt = (cmd_r == BESCP_CMD_MRG) ? BESCP_S_ARG2 : BESCP_S_TEXT;
				end
			end
			BESCP_S_ARG2: begin
				if (take) state_nxt = BESCP_S_TEXT;
			end
			BESCP_S_FLUSH: begin
				// host waits for a full stop, so idle marks the volume printed
				// the release pulse of this flush must reach the engine first
				if (engine_idle_i && !ctl_r.release_pg) state_nxt = BESCP_S_BLANK;
			end
			BESCP_S_BLANK: begin
				ctl_nxt.blank_sheet = 1'b1;
				state_nxt           = BESCP_S_HOME;
			end
			BESCP_S_HOME: begin
				ctl_nxt.home = 1'b1;
				state_nxt    = BESCP_S_TEXT;
			end
			default: state_nxt = BESCP_S_TEXT;
		endcase
	end

	// state and engine commands
	// with ce low a pulse stands until ce returns; the engine must gate on ce
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= BESCP_S_TEXT;
			ctl_r   <= '0;
		end else if (ce_i) begin
			state_r <= state_nxt;
			ctl_r   <= ctl_nxt;
		end
	end

	// command letter and tens digit capture
	// arguments are judged only once the last digit is in
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_r  <= 8'h00;
			tens_r <= 8'h00;
		end else if (take) begin
			if (state_r == BESCP_S_ESC) cmd_r <= in_data_i;
			if (state_r == BESCP_S_ARG1) tens_r <= is_digit(in_data_i) ?
				(in_data_i - BESCP_DIG_0) : 8'hff;
		end
	end

	// line and held-page tracking
	// a reset or flush never meets a closing page in one cycle, since
	// text is taken only in the text state
	wire sff_taken = take && (state_r == BESCP_S_ESC) && (in_data_i == BESCP_CMD_SFF);
	wire rst_taken = take && (state_r == BESCP_S_ESC) && (in_data_i == BESCP_CMD_RST);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			line_cnt_r <= 6'h0;
			held_r     <= 1'b0;
		end else if (ce_i) begin
			if (sff_taken || rst_taken) begin
				line_cnt_r <= 6'h0;
				held_r     <= 1'b0;
			end else if (close_pg) begin
				line_cnt_r <= 6'h0;
				held_r     <= cfg_r.duplex && !held_r;
			end else if (end_line) begin
				line_cnt_r <= next_line;
			end
		end
	end

	// ---------------- wishbone slave ----------------
	// decode uses the address held with the request; sel lanes 2 and 3 unused
	wire wb_req  = wb_cyc_i && wb_stb_i && !ack_r;
	wire wb_wr   = ce_i && wb_req && wb_we_i;
	wire hit_cfg = (wb_adr_i == BESCP_CFG_OFF);
	wire hit_mod = (wb_adr_i == BESCP_MODE_OFF);
	wire hit_sts = (wb_adr_i == BESCP_STATUS_OFF);
	wire hit_geo = (wb_adr_i == BESCP_GEOM_OFF);
	wire [3:0] wr_adj   = wb_dat_i[7:4];
	wire [3:0] wr_sheet = wb_dat_i[11:8];
	wire [4:0] wr_mrg   = wb_dat_i[12:8];
	// register images as the bus map lays them out
	wire [31:0] cfg_word = {20'h0, cfg_r.sheet_in, cfg_r.adjust, cfg_r.dbl_space,
		cfg_r.dot8, cfg_r.zfold, cfg_r.duplex};
	wire [31:0] mod_word = {19'h0, margin_r, 7'h0, ffm_r};
	wire [31:0] sts_word = {7'h0, engine_idle_i, 7'h0, held_r, 2'h0, line_cnt_r,
		4'h0, held_r, state_r};
	wire [31:0] geo_word = {11'h0, bottom_steps_o, 3'h0, top_steps_o, 2'h0, lines_o};
	wire [31:0] rd_word;
	// unmapped addresses answer with zero
	assign rd_word = hit_cfg ? cfg_word : hit_mod ? mod_word : hit_sts ? sts_word :
		hit_geo ? geo_word : 32'h0;

	// one-cycle answer; ack drops the cycle after it was given
	// read data refreshes every enabled cycle; the master takes it with ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r  <= 1'b0;
			rdat_r <= 32'h0;
		end else if (ce_i) begin
			ack_r  <= wb_req;
			rdat_r <= rd_word;
		end
	end
	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;

	// page format settings; illegal field values are not taken
	// a bad sheet length keeps the old one, so the lookup never misses
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_r <= BESCP_CFG_RST;
		end else if (wb_wr && hit_cfg) begin
			if (wb_sel_i[0]) begin
				cfg_r.duplex    <= wb_dat_i[0];
				cfg_r.zfold     <= wb_dat_i[1];
				cfg_r.dot8      <= wb_dat_i[2];
				cfg_r.dbl_space <= wb_dat_i[3];
				if (wr_adj <= BESCP_ADJ_MAX) cfg_r.adjust <= wr_adj;
			end
			if (wb_sel_i[1] && wr_sheet >= BESCP_SHEET_MIN && wr_sheet <= BESCP_SHEET_MAX) begin
				cfg_r.sheet_in <= wr_sheet;
			end
		end
	end

	// form-feed mode and margin from host escapes or software
	// escape and software write in one cycle: the host escape wins
	wire esc_ffm = take && (state_r == BESCP_S_ARG1) && (cmd_r == BESCP_CMD_FFM);
	wire esc_mrg = take && (state_r == BESCP_S_ARG2) && (cmd_r == BESCP_CMD_MRG);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ffm_r    <= BESCP_FFM_RST;
			margin_r <= BESCP_MARGIN_RST;
		end else if (ce_i) begin
			if (esc_ffm && ffm_digit) begin
				ffm_r <= (in_data_i == BESCP_DIG_1);
			end else if (wb_wr && hit_mod && wb_sel_i[0]) begin
				ffm_r <= wb_dat_i[0];
			end
			if (esc_mrg && mrg_legal) begin
				margin_r <= mrg_val[4:0];
			end else if (wb_wr && hit_mod && wb_sel_i[1] && wr_mrg <= BESCP_MARGIN_MAX) begin
				margin_r <= wr_mrg;
			end
		end
	end

	// margin toward the engine: both edges when two-sided, top only otherwise
	// registered so the engine sees one settled value per cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			top_steps_o    <= BESCP_MARGIN_RST;
			bottom_steps_o <= BESCP_MARGIN_RST;
			lines_o        <= 6'h0;
		end else if (ce_i) begin
			top_steps_o    <= margin_r;
			bottom_steps_o <= cfg_r.duplex ? margin_r : 5'h0;
			lines_o        <= lpp_eff;
		end
	end
	// engine pulses straight from flops
	assign ctl_o = ctl_r;

	// text path; command bytes never reach it
	// two entries let a full-rate stream go on; a stalled receiver stops it after two bytes
	bescp_buf2 u_buf (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.s_valid_i (push_text),
		.s_data_i  (in_data_i),
		.s_ready_o (buf_ready),
		.m_valid_o (out_valid_o),
		.m_data_o  (out_data_o),
		.m_ready_i (out_ready_i)
	);

endmodule // bescp_parser
`default_nettype wire

// [core/bescp_pkg.sv]
package bescp_pkg;

	// bus map, byte addresses of aligned 32-bit words
	localparam logic [7:0] BESCP_CFG_OFF    = 8'h00;
	localparam logic [7:0] BESCP_MODE_OFF   = 8'h04;
	localparam logic [7:0] BESCP_STATUS_OFF = 8'h08;
	localparam logic [7:0] BESCP_GEOM_OFF   = 8'h0c;

	// host byte codes
	localparam logic [7:0] BESCP_ESC     = 8'h1b;
	localparam logic [7:0] BESCP_LF      = 8'h0a;
	localparam logic [7:0] BESCP_FF      = 8'h0c;
	localparam logic [7:0] BESCP_CMD_FFM = 8'h53;
	localparam logic [7:0] BESCP_CMD_MRG = 8'h54;
	localparam logic [7:0] BESCP_CMD_RST = 8'h30;
	localparam logic [7:0] BESCP_CMD_SFF = 8'h31;
	localparam logic [7:0] BESCP_DIG_0   = 8'h30;
	localparam logic [7:0] BESCP_DIG_1   = 8'h31;
	localparam logic [7:0] BESCP_DIG_9   = 8'h39;

	// limits and reset values
	localparam logic [4:0] BESCP_MARGIN_MAX = 5'h14;
	localparam logic [4:0] BESCP_MARGIN_RST = 5'h08;
	localparam logic [3:0] BESCP_ADJ_MAX    = 4'h9;
	localparam logic [3:0] BESCP_SHEET_MIN  = 4'h4;
	localparam logic [3:0] BESCP_SHEET_MAX  = 4'he;
	localparam logic [3:0] BESCP_SHEET_RST  = 4'hc;
	localparam logic       BESCP_FFM_RST    = 1'b1;
	localparam logic       BESCP_DUPLEX_RST = 1'b1;
	// line pitch in 0.3175 mm units; one margin step is two of them
	localparam logic [5:0] BESCP_PITCH_NORM = 6'h10;
	localparam logic [5:0] BESCP_PITCH_DBL  = 6'h20;

	// page format settings written by software
	typedef struct packed {
		logic       duplex;
		logic       zfold;
		logic       dot8;
		logic       dbl_space;
		logic [3:0] adjust;
		logic [3:0] sheet_in;
	} bescp_cfg_type;

	localparam bescp_cfg_type BESCP_CFG_RST = '{BESCP_DUPLEX_RST, 1'b0, 1'b0, 1'b0,
		4'h0, BESCP_SHEET_RST};

	// one-cycle commands toward the print engine
	typedef struct packed {
		logic       release_pg;
		logic [1:0] pages;
		logic       blank_sheet;
		logic       home;
		logic       discard;
		logic       origin;
	} bescp_ctl_type;

	// parser states, gray along text -> esc -> args -> flush sequence
	typedef enum logic [2:0] {
		BESCP_S_TEXT  = 3'b000,
		BESCP_S_ESC   = 3'b001,
		BESCP_S_ARG1  = 3'b011,
		BESCP_S_ARG2  = 3'b010,
		BESCP_S_FLUSH = 3'b110,
		BESCP_S_BLANK = 3'b111,
		BESCP_S_HOME  = 3'b101
	} bescp_state_type;

endpackage

// [core/bescp_buf2.sv]
`timescale 1ns/1ps
`default_nettype none
module bescp_buf2
	import bescp_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	// filling side
	input  wire logic       s_valid_i,
	input  wire logic [7:0] s_data_i,
	output logic            s_ready_o,
	// draining side
	output logic            m_valid_o,
	output logic [7:0]      m_data_o,
	input  wire logic       m_ready_i
);

	logic [7:0] mem_r [2];
	logic       wr_ptr_r;
	logic       rd_ptr_r;
	logic [1:0] count_r;
	wire        push = ce_i & s_valid_i & s_ready_o;
	wire        pop  = ce_i & m_valid_o & m_ready_i;

	// two entries so a stalled receiver never drops a word
	assign s_ready_o = (count_r != 2'h2);
	assign m_valid_o = (count_r != 2'h0);
	assign m_data_o  = mem_r[rd_ptr_r];

	// storage written only, no reset needed
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wr_ptr_r] <= s_data_i;
		end
	end

	// pointers and fill level
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			count_r  <= 2'h0;
		end else begin
			if (push) wr_ptr_r <= ~wr_ptr_r;
			if (pop) rd_ptr_r <= ~rd_ptr_r;
			if (push & ~pop) count_r <= count_r + 2'h1;
			else if (pop & ~push) count_r <= count_r - 2'h1;
		end
	end

endmodule // bescp_buf2
`default_nettype wire

// [verification/bescp_parser_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module bescp_parser_checker
	import bescp_pkg::*;
(
	// clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          ce_i,
	// bus handshake
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_ack_o,
	// byte streams
	input  wire logic          in_valid_i,
	input  wire logic [7:0]    in_data_i,
	input  wire logic          in_ready_o,
	input  wire logic          out_valid_o,
	input  wire logic [7:0]    out_data_o,
	input  wire logic          out_ready_i,
	// engine side
	input  wire logic          engine_idle_i,
	input  wire bescp_ctl_type ctl_o,
	input  wire logic [4:0]    top_steps_o,
	input  wire logic [4:0]    bottom_steps_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// shadow decoder; ignores escape bytes hidden inside arguments
	logic       esc_r;
	logic [1:0] skip_r;
	wire take = in_valid_i && in_ready_o && ce_i;
	wire arg  = take && (esc_r || skip_r != 2'h0);
	wire txt  = take && !arg && in_data_i != BESCP_ESC;
	wire srst = take && esc_r && in_data_i == BESCP_CMD_RST;
	wire sff  = take && esc_r && in_data_i == BESCP_CMD_SFF;

	// argument count per command
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			esc_r  <= 1'b0;
			skip_r <= 2'h0;
		end else if (take) begin
			esc_r  <= !arg && in_data_i == BESCP_ESC;
			skip_r <= esc_r ? (in_data_i == BESCP_CMD_MRG ? 2'h2 : {1'b0, in_data_i == BESCP_CMD_FFM})
				: skip_r - {1'b0, skip_r != 2'h0};
		end
	end

	a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_margin_limit: assert property (top_steps_o <= BESCP_MARGIN_MAX)
		else $error("margin above limit");
	a_margin_both: assert property (bottom_steps_o != 5'h00 |-> bottom_steps_o == top_steps_o)
		else $error("bottom margin differs from top");
	a_margin_reset: assert property ($fell(rst_i) |-> top_steps_o == 5'h08 && bottom_steps_o == 5'h08)
		else $error("margin not 8 after reset");
	a_soft_reset: assert property (srst |=> ctl_o.discard && ctl_o.origin)
		else $error("soft reset pulses missing");
	a_flush_hold: assert property (sff |=> !in_ready_o [*3])
		else $error("input accepted during flush");
	a_blank_idle: assert property (ctl_o.blank_sheet |-> $past(engine_idle_i, 2))
		else $error("blank sheet before engine stopped");
	a_home_after: assert property (ctl_o.blank_sheet |=> ctl_o.home)
		else $error("home does not follow blank sheet");
	a_arg_silent: assert property (take && !txt && !out_valid_o |=> !out_valid_o)
		else $error("command byte printed");
	a_text_out: assert property (txt |=> out_valid_o)
		else $error("text byte not shown next cycle");
	a_stall_hold: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
		else $error("stalled byte lost");
endmodule // bescp_parser_checker

bind bescp_parser bescp_parser_checker bescp_parser_checker_inst (
	.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .in_valid_i(in_valid_i), .in_data_i(in_data_i),
	.in_ready_o(in_ready_o), .out_valid_o(out_valid_o), .out_data_o(out_data_o),
	.out_ready_i(out_ready_i), .engine_idle_i(engine_idle_i), .ctl_o(ctl_o),
	.top_steps_o(top_steps_o), .bottom_steps_o(bottom_steps_o)
);
`default_nettype wire

// [verification/bescp_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module bescp_host_model
	import bescp_pkg::*;
(
	// clock and reset
	input  wire logic  clk_i,
	input  wire logic  rst_i,
	input  wire logic  ce_i,
	// byte stream toward the parser
	output logic       valid_o,
	output logic [7:0] data_o,
	input  wire logic  ready_i
);
	logic [7:0] pend_q[$];

	// bytes go out exactly as queued, no escape is altered
	task automatic put(input logic [7:0] b);
		pend_q.push_back(b);
	endtask

	// hold each byte until taken; idle line toggles so no stale value passes
	always @(posedge clk_i) begin
		if (rst_i) begin
			valid_o <= 1'b0;
			data_o  <= 8'h5a;
		end else if (!valid_o || (ready_i && ce_i)) begin
			if (pend_q.size() != 0) begin
				valid_o <= 1'b1;
				data_o  <= pend_q.pop_front();
			end else begin
				valid_o <= 1'b0;
				data_o  <= ~data_o;
			end
		end
	end
endmodule // bescp_host_model
`default_nettype wire

// [verification/bescp_parser_test.sv]
`timescale 1ns/1ps
`default_nettype none
module bescp_parser_test
	import bescp_pkg::*;
;
	localparam logic [7:0]  FD[3] = '{8'h30, 8'h35, 8'h31};
	localparam logic [31:0] FE[3] = '{0, 0, 1};
	localparam logic [7:0]  MT[4] = '{8'h32, 8'h32, 8'h30, 8'h31};
	localparam logic [7:0]  MU[4] = '{8'h30, 8'h31, 8'h30, 8'h32};
	localparam logic [31:0] ME[4] = '{20, 20, 0, 12};
	localparam logic [31:0] LC[9] = '{'hc01, 'hc05, 'hc09, 'hc0d, 'h401, 'he0d, 'hc41, 'hc95, 'hf01};
	localparam logic [31:0] LE[9] = '{29, 23, 19, 16, 9, 19, 25, 14, 29};

	logic          clk_i = 1'b0;
	logic          rst_i = 1'b1;
	logic          wb_cyc = 1'b0;
	logic          wb_stb = 1'b0;
	logic          wb_we = 1'b0;
	logic [7:0]    wb_adr = 8'h00;
	logic [31:0]   wb_dat = 32'h0;
	logic          out_ready = 1'b1;
	logic          ce = 1'b1;
	logic [1:0]    last_pages = 2'h0;
	logic          engine_idle = 1'b1;
	logic [31:0]   wb_dat_o, rd_data;
	logic          wb_ack_o, in_valid, in_ready_o, out_valid_o;
	logic [7:0]    in_data, out_data_o;
	bescp_ctl_type ctl_o;
	logic [4:0]    top_steps_o, bottom_steps_o;
	logic [5:0]    lines_o;
	logic [7:0]    got_q[$], lf_q[$];
	int            failures = 0, checks_done = 0, cycles = 0;
	int            n_rel = 0, n_blank = 0, n_home = 0, n_disc = 0, n_orig = 0;

	always #50 clk_i = ~clk_i;

	bescp_parser bescp_parser_inst (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(4'h3), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.in_valid_i(in_valid), .in_data_i(in_data), .in_ready_o(in_ready_o),
		.out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_ready_i(out_ready),
		.engine_idle_i(engine_idle), .ctl_o(ctl_o), .top_steps_o(top_steps_o),
		.bottom_steps_o(bottom_steps_o), .lines_o(lines_o)
	);
	bescp_host_model bescp_host_model_inst (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .valid_o(in_valid), .data_o(in_data),
		.ready_i(in_ready_o)
	);

	// count engine pulses and collect printed text
	always @(posedge clk_i) begin
		if (out_valid_o === 1'b1 && out_ready && ce) got_q.push_back(out_data_o);
		if (ctl_o.release_pg === 1'b1) last_pages <= ctl_o.pages;
		n_rel   += int'(ctl_o.release_pg === 1'b1);
		n_blank += int'(ctl_o.blank_sheet === 1'b1);
		n_home  += int'(ctl_o.home === 1'b1);
		n_disc  += int'(ctl_o.discard === 1'b1);
		n_orig  += int'(ctl_o.origin === 1'b1);
	end

	// hang guard, well above the several hundred cycles used
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one classic cycle, held until ack is sampled
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= we;
		wb_adr <= adr;
		wb_dat <= dat;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 100);
		check("bus ack", 1, {31'h0, wb_ack_o});
		rd_data = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
		@(posedge clk_i);
	endtask

	// hand bytes to the host and wait until all are taken or 200 cycles pass
	task automatic send(input logic [7:0] b[$]);
		foreach (b[i]) bescp_host_model_inst.put(b[i]);
		for (int i = 0; i < 200 && (bescp_host_model_inst.pend_q.size() != 0 || in_valid); i++)
			@(posedge clk_i);
		repeat (3) @(posedge clk_i);
	endtask

	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		wb(1'b0, BESCP_MODE_OFF, 32'h0);
		check("mode", 32'h801, rd_data & 32'h1f01);
		wb(1'b0, BESCP_CFG_OFF, 32'h0);
		check("cfg", 32'hc01, rd_data & 32'hfff);
		wb(1'b0, 8'h10, 32'h0);
		check("unmapped", 0, rd_data);
		check("top", 8, top_steps_o);
		check("bottom", 8, bottom_steps_o);
		$display("test defaults done");
		foreach (LC[i]) begin
			wb(1'b1, BESCP_CFG_OFF, LC[i]);
			check("lines", LE[i], lines_o);
		end
		$display("test page geometry done");
		foreach (FD[i]) begin
			send('{BESCP_ESC, BESCP_CMD_FFM, FD[i]});
			wb(1'b0, BESCP_MODE_OFF, 32'h0);
			check("ff mode", FE[i], rd_data & 32'h1);
		end
		foreach (MT[i]) begin
			send('{BESCP_ESC, BESCP_CMD_MRG, MT[i], MU[i]});
			wb(1'b0, BESCP_MODE_OFF, 32'h0);
			check("margin", ME[i], rd_data[12:8]);
			check("top", ME[i], top_steps_o);
			check("bottom", ME[i], bottom_steps_o);
		end
		check("printed", 0, got_q.size());
		$display("test escape settings done");
		wb(1'b1, BESCP_CFG_OFF, 32'hc00);
		check("top", 12, top_steps_o);
		check("bottom", 0, bottom_steps_o);
		// 27 lines overflow a 29 line page once a 12 step offset is added
		repeat (27) lf_q.push_back(BESCP_LF);
		send(lf_q);
		check("pages out", 1, n_rel);
		check("printed", 27, got_q.size());
		check("pages", 1, {30'h0, last_pages});
		$display("test single sided done");
		wb(1'b1, BESCP_CFG_OFF, 32'hc01);
		got_q.delete();
		out_ready <= 1'b0;
		send('{8'h41, 8'h42, 8'h43, 8'h44});
		check("ready full", 0, {31'h0, in_ready_o});
		check("printed", 0, got_q.size());
		out_ready <= 1'b1;
		repeat (10) @(posedge clk_i);
		check("printed", 4, got_q.size());
		foreach (got_q[i]) check("text", 32'h41 + i, got_q[i]);
		$display("test buffer stall done");
		engine_idle <= 1'b0;
		send('{8'h41, BESCP_LF, BESCP_FF, 8'h42, BESCP_LF});
		check("held", 1, n_rel);
		wb(1'b0, BESCP_STATUS_OFF, 32'h0);
		check("held flag", 1, {31'h0, rd_data[3]});
		send('{BESCP_ESC, BESCP_CMD_SFF});
		repeat (10) @(posedge clk_i);
		check("flush hold", 0, {31'h0, in_ready_o});
		check("blank early", 0, n_blank);
		engine_idle <= 1'b1;
		repeat (10) @(posedge clk_i);
		check("release", 2, n_rel);
		check("pages", 2, {30'h0, last_pages});
		check("blank", 1, n_blank);
		check("home", 1, n_home);
		check("flush ready", 1, {31'h0, in_ready_o});
		$display("test soft form feed done");
		send('{BESCP_ESC, BESCP_CMD_RST});
		check("discard", 1, n_disc);
		check("origin", 1, n_orig);
		$display("test soft reset done");
		got_q.delete();
		ce <= 1'b0;
		send('{8'h45});
		check("frozen", 0, got_q.size());
		check("byte waits", 1, {31'h0, in_valid});
		ce <= 1'b1;
		repeat (5) @(posedge clk_i);
		check("printed", 1, got_q.size());
		check("text", 32'h45, {24'h0, got_q[0]});
		$display("test clock enable done");
		finish_test();
	end
endmodule // bescp_parser_test
`default_nettype wire
